//--- hdl/refpg_core.sv
// reference setpoint, margining and in-regulation supervision
// assumes command writes decoded by an outer pmbus engine, one cycle each
`include "refpg_params.svh"
module refpg_core
  import refpg_pkg::*;
#(
  parameter int CODE_W = 16
)
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // command port
  input wire refpg_cmd_t cmd_i,
  output logic [15:0] rdata_o,
  // sensing
  input wire refpg_sense_t sense_i,
  input wire logic slave_strap_i,
  input wire logic sync_clk_i,
  input wire logic shared_comp_line_i,
  // nonvolatile store
  output logic nv_store_o,
  output logic [7:0] nv_trim_o,
  // outputs
  output logic [CODE_W-1:0] error_amp_reference_o,
  output logic in_regulation_out_o,
  output logic in_regulation_out_oe_o,
  output logic overvoltage_warning_o,
  output logic shared_comp_line_o,
  output logic shared_comp_line_oe_o,
  output logic switch_enable_o,
  output logic switch_lock_o,
  output refpg_margin_t margin_state_o,
  output refpg_role_t role_o
);
  typedef struct packed {
    logic [7:0] operation;
    logic [15:0] vout_cmd;
    logic half_scale;
    logic [7:0] trim;
    logic [7:0] step_hi;
    logic [7:0] step_lo;
    logic [7:0] pct_limits;
    logic [15:0] ref_code;
    logic [15:0] rdata;
    logic pg_low;
    logic overvoltage_warning;
    logic comp_pull;
    logic sw_en;
    logic store;
    logic [7:0] nv_trim;
    logic role_taken;
    refpg_role_t role;
    logic lock;
    refpg_margin_t mstate;
  } refpg_state_t;
  refpg_state_t s_q, s_d;
  logic lock_pulse;
  logic signed [17:0] sum;
  logic signed [17:0] scaled;
  logic [17:0] ref_abs;
  logic [17:0] ov_lim;
  logic [17:0] uv_lim;
  logic [17:0] pre_lim;
  logic [17:0] fb;
  logic [3:0] ov_pct;
  logic [3:0] uv_pct;
  logic any_fault;

  refpg_edge_lock u_lock (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .use_fall_i(s_q.role == REFPG_ROLE_SLAVE),
    .sync_clk_i(sync_clk_i),
    .lock_pulse_o(lock_pulse)
  );

  function automatic logic [7:0] clamp8(input logic [7:0] v, input int lo, input int hi);
    int x;
    x = int'($signed(v));
    if (x < lo) begin
      x = lo;
    end else if (x > hi) begin
      x = hi;
    end
    return x[7:0];
  endfunction

  always_comb begin
    s_d = s_q;
    s_d.store = 1'b0;
    // register writes
    if (cmd_i.wr) begin
      if (cmd_i.addr == `REFPG_OFS_OPERATION) begin
        s_d.operation = cmd_i.wdata[7:0];
      end else if (cmd_i.addr == `REFPG_OFS_VOUT_CMD) begin
        s_d.vout_cmd = cmd_i.wdata;
      end else if (cmd_i.addr == `REFPG_OFS_SCALE_LOOP) begin
        s_d.half_scale = cmd_i.wdata[0];
      end else if (cmd_i.addr == `REFPG_OFS_VREF_TRIM) begin
        s_d.trim = clamp8(cmd_i.wdata[7:0], `REFPG_TRIM_MIN, `REFPG_TRIM_MAX);
      end else if (cmd_i.addr == `REFPG_OFS_MARGIN_HIGH) begin
        s_d.step_hi = clamp8(cmd_i.wdata[7:0], `REFPG_STEP_MIN, `REFPG_STEP_MAX);
      end else if (cmd_i.addr == `REFPG_OFS_MARGIN_LOW) begin
        s_d.step_lo = clamp8(cmd_i.wdata[7:0], `REFPG_STEP_MIN, `REFPG_STEP_MAX);
      end else if (cmd_i.addr == `REFPG_OFS_PCT_LIMITS) begin
        s_d.pct_limits = cmd_i.wdata[7:0];
      end else if (cmd_i.addr == `REFPG_OFS_STORE_ALL) begin
        s_d.store = 1'b1;
        s_d.nv_trim = s_q.trim;
      end
    end
    // read mux
    if (cmd_i.addr == `REFPG_OFS_OPERATION) begin
      s_d.rdata = {8'h00, s_q.operation};
    end else if (cmd_i.addr == `REFPG_OFS_VOUT_CMD) begin
      s_d.rdata = s_q.vout_cmd;
    end else if (cmd_i.addr == `REFPG_OFS_SCALE_LOOP) begin
      s_d.rdata = {15'h0, s_q.half_scale};
    end else if (cmd_i.addr == `REFPG_OFS_VREF_TRIM) begin
      s_d.rdata = {8'h00, s_q.trim};
    end else if (cmd_i.addr == `REFPG_OFS_MARGIN_HIGH) begin
      s_d.rdata = {8'h00, s_q.step_hi};
    end else if (cmd_i.addr == `REFPG_OFS_MARGIN_LOW) begin
      s_d.rdata = {8'h00, s_q.step_lo};
    end else if (cmd_i.addr == `REFPG_OFS_PCT_LIMITS) begin
      s_d.rdata = {8'h00, s_q.pct_limits};
    end else begin
      s_d.rdata = s_q.ref_code;
    end
    // reference sum
    scaled = s_q.half_scale ? $signed({3'b000, s_q.vout_cmd[15:1]}) :
      $signed({2'b00, s_q.vout_cmd});
    sum = scaled + 18'(signed'(s_q.trim));
    if (s_q.operation[`REFPG_OP_MARGIN_HI_BIT]) begin
      sum = sum + 18'(signed'(s_q.step_hi));
    end
    if (s_q.operation[`REFPG_OP_MARGIN_LO_BIT]) begin
      sum = sum + 18'(signed'(s_q.step_lo));
    end
    if (sum < $signed(`REFPG_DAC_MIN)) begin
      ref_abs = `REFPG_DAC_MIN;
    end else if (sum > $signed(`REFPG_DAC_MAX)) begin
      ref_abs = `REFPG_DAC_MAX;
    end else begin
      ref_abs = 18'(sum);
    end
    s_d.ref_code = ref_abs[15:0];
    // window from percent nibbles, steps of one percent
    ov_pct = s_q.pct_limits[7:4];
    uv_pct = s_q.pct_limits[3:0];
    ov_lim = ref_abs + 18'((ref_abs * ov_pct) / 100);
    uv_lim = ref_abs - 18'((ref_abs * uv_pct) / 100);
    pre_lim = ref_abs + 18'((ref_abs * `REFPG_PREBIAS_PCT) / 100);
    fb = {2'b00, sense_i.fb_code};
    // prebias trip only once the 6v rail is up
    s_d.overvoltage_warning = sense_i.rail6_ok && (fb > pre_lim || fb > ov_lim);
    any_fault = sense_i.fault | ~shared_comp_line_i;
    s_d.comp_pull = sense_i.fault;
    s_d.sw_en = ~any_fault;
    s_d.pg_low = ~(~any_fault && ~s_d.overvoltage_warning && (fb >= uv_lim) && (fb <= ov_lim));
    // role caught once after reset release
    if (!s_q.role_taken) begin
      s_d.role_taken = 1'b1;
      s_d.role = slave_strap_i ? REFPG_ROLE_SLAVE : REFPG_ROLE_MASTER;
    end
    // lock pulse and margin state registered with the rest
    s_d.lock = lock_pulse;
    if (s_q.operation[`REFPG_OP_MARGIN_HI_BIT]) begin
      s_d.mstate = REFPG_MARGIN_HIGH;
    end else if (s_q.operation[`REFPG_OP_MARGIN_LO_BIT]) begin
      s_d.mstate = REFPG_MARGIN_LOW;
    end else begin
      s_d.mstate = REFPG_MARGIN_NONE;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
      s_q.vout_cmd <= `REFPG_RST_VOUT_CMD;
      s_q.pct_limits <= `REFPG_RST_PCT_LIMITS;
      s_q.role <= REFPG_ROLE_STANDALONE;
      s_q.pg_low <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_o = s_q.rdata;
  assign nv_store_o = s_q.store;
  assign nv_trim_o = s_q.nv_trim;
  assign error_amp_reference_o = CODE_W'(s_q.ref_code);
  assign in_regulation_out_o = 1'b0;
  assign in_regulation_out_oe_o = s_q.pg_low;
  assign overvoltage_warning_o = s_q.overvoltage_warning;
  assign shared_comp_line_o = 1'b0;
  assign shared_comp_line_oe_o = s_q.comp_pull;
  assign switch_enable_o = s_q.sw_en;
  assign switch_lock_o = s_q.lock;
  assign margin_state_o = s_q.mstate;
  assign role_o = s_q.role;
endmodule

//--- hdl/refpg_params.svh
// constants for the reference setpoint and in-regulation block
// assumes inclusion by the core, the monitor and the bench
`ifndef REFPG_PARAMS_SVH
`define REFPG_PARAMS_SVH
`define REFPG_OFS_MARGIN_HIGH 8'hD5
`define REFPG_OFS_MARGIN_LOW 8'hD6
`define REFPG_OFS_PCT_LIMITS 8'hD7
`define REFPG_OFS_OPERATION 8'h01
`define REFPG_OFS_VOUT_CMD 8'h21
`define REFPG_OFS_SCALE_LOOP 8'h29
`define REFPG_OFS_VREF_TRIM 8'hD4
`define REFPG_OFS_STORE_ALL 8'h11
`define REFPG_OP_MARGIN_HI_BIT 5
`define REFPG_OP_MARGIN_LO_BIT 4
`define REFPG_TRIM_MIN (-64)
`define REFPG_TRIM_MAX 63
`define REFPG_STEP_MIN (-64)
`define REFPG_STEP_MAX 31
`define REFPG_DAC_MIN 18'h000B3
`define REFPG_DAC_MAX 18'h0034D
`define REFPG_PREBIAS_PCT 5
`define REFPG_RST_PCT_LIMITS 8'h00
`define REFPG_RST_VOUT_CMD 16'h0200
`endif

//--- hdl/refpg_pkg.sv
// types for the reference setpoint and in-regulation block
// assumes refpg_params.svh on the include path
package refpg_pkg;
  typedef enum logic [1:0] {
    REFPG_MARGIN_NONE,
    REFPG_MARGIN_HIGH,
    REFPG_MARGIN_LOW
  } refpg_margin_t;
  typedef enum logic [1:0] {
    REFPG_ROLE_STANDALONE,
    REFPG_ROLE_MASTER,
    REFPG_ROLE_SLAVE
  } refpg_role_t;
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [15:0] wdata;
  } refpg_cmd_t;
  typedef struct packed {
    logic [15:0] fb_code;
    logic rail6_ok;
    logic fault;
  } refpg_sense_t;
endpackage

//--- hdl/refpg_edge_lock.sv
// edge selector for switching lock to the shared sync clock
// assumes the sync input is already synchronous to core_clk_i
module refpg_edge_lock
  import refpg_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic use_fall_i,
  input wire logic sync_clk_i,
  // result
  output logic lock_pulse_o
);
  typedef struct packed {
    logic armed;
    logic prev;
    logic pulse;
  } refpg_lock_state_t;
  refpg_lock_state_t s_q, s_d;
  always_comb begin
    s_d = s_q;
    // no edge reported until prev holds a real sample after reset
    s_d.armed = 1'b1;
    s_d.prev = sync_clk_i;
    s_d.pulse = s_q.armed & (use_fall_i ? (s_q.prev & ~sync_clk_i) : (~s_q.prev & sync_clk_i));
  end
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign lock_pulse_o = s_q.pulse;
endmodule

//--- verif/refpg_monitor.sv
// port assertions for the reference and supervision block
// assumes bind onto refpg_core and a single clock domain
`include "refpg_params.svh"
module refpg_monitor
  import refpg_pkg::*;
#(
  parameter int CODE_W = 16
)
(
  // inputs seen
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire refpg_cmd_t cmd_i,
  input wire refpg_sense_t sense_i,
  input wire logic sync_clk_i,
  input wire logic shared_comp_line_i,
  // outputs seen
  input wire logic nv_store_o,
  input wire logic [CODE_W-1:0] error_amp_reference_o,
  input wire logic in_regulation_out_o,
  input wire logic in_regulation_out_oe_o,
  input wire logic overvoltage_warning_o,
  input wire logic shared_comp_line_o,
  input wire logic shared_comp_line_oe_o,
  input wire logic switch_enable_o,
  input wire logic switch_lock_o,
  input wire refpg_role_t role_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_PG_OD: assert property (!in_regulation_out_o) else $error("pg driven high");
  AST_SH_OD: assert property (!shared_comp_line_o) else $error("shared line driven high");
  AST_FLT_PG: assert property (sense_i.fault |-> ##[1:2] in_regulation_out_oe_o)
    else $error("pg kept on fault");
  AST_FLT_SH: assert property (sense_i.fault |-> ##[1:2] shared_comp_line_oe_o)
    else $error("shared line not pulled");
  AST_PRT_STOP: assert property (!shared_comp_line_i |-> ##[1:2] !switch_enable_o)
    else $error("switching on partner fault");
  AST_OVW_PG: assert property (overvoltage_warning_o |-> ##[0:1] in_regulation_out_oe_o)
    else $error("pg kept on warning");
  AST_REF_SPAN: assert property ($past(rst_n_i, 2) |->
    error_amp_reference_o >= `REFPG_DAC_MIN && error_amp_reference_o <= `REFPG_DAC_MAX)
    else $error("reference out of span");
  AST_STORE: assert property (cmd_i.wr && cmd_i.addr == `REFPG_OFS_STORE_ALL
    |-> ##[1:2] nv_store_o) else $error("no store pulse");
  AST_LOCK_R: assert property ($past(rst_n_i, 3) && role_o != REFPG_ROLE_SLAVE
    && $rose(sync_clk_i) |-> ##[1:4] switch_lock_o) else $error("no rising lock");
  AST_LOCK_F: assert property ($past(rst_n_i, 3) && role_o == REFPG_ROLE_SLAVE
    && $fell(sync_clk_i) |-> ##[1:4] switch_lock_o) else $error("no falling lock");
  cover property (sense_i.fault);
  cover property (nv_store_o);
  cover property (role_o == REFPG_ROLE_SLAVE && switch_lock_o);
endmodule
bind refpg_core refpg_monitor #(.CODE_W(CODE_W)) i_refpg_monitor (.core_clk_i, .rst_n_i,
  .cmd_i, .sense_i, .sync_clk_i, .shared_comp_line_i, .nv_store_o, .error_amp_reference_o,
  .in_regulation_out_o, .in_regulation_out_oe_o, .overvoltage_warning_o,
  .shared_comp_line_o, .shared_comp_line_oe_o, .switch_enable_o, .switch_lock_o, .role_o);

//--- verif/refpg_partner.sv
// paralleled second module: sync clock source and shared line pull
// assumes sync edges land just after core clock edges
module refpg_partner #(
  parameter int HALF = 4
)
(
  // clock and control
  input wire logic core_clk_i,
  input wire logic fault_i,
  // pins
  output logic sync_o,
  output logic pull_low_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt = 0;
  initial sync_o = 1'b0;
  always @(posedge core_clk_i) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) sync_o <= !sync_o;
  end
  assign pull_low_o = fault_i;
endmodule

//--- verif/tb_top.sv
// self-checking bench for the reference setpoint block
// assumes the partner model and the bound monitor
`include "refpg_params.svh"
module tb_top
  import refpg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, rst_n = 0, strap = 0, pflt = 0;
  refpg_cmd_t cmd = '0;
  refpg_sense_t sense = '0;
  logic [15:0] rdata, ref_o;
  logic pg_oe, overvoltage_warning, sh_oe, sw_en, nv_st, sync, plow;
  logic [7:0] nv_trim;
  refpg_margin_t mst;
  refpg_role_t role;
  wire shared = !(sh_oe || plow);
  wire seq_ctl = !pg_oe;
  int error_cnt = 0, n_checks = 0;
  always #12.5 clk = !clk;
  refpg_partner i_refpg_partner (.core_clk_i(clk), .fault_i(pflt), .sync_o(sync),
    .pull_low_o(plow));
  refpg_core i_refpg_core (.core_clk_i(clk), .rst_n_i(rst_n), .cmd_i(cmd), .rdata_o(rdata),
    .sense_i(sense), .slave_strap_i(strap), .sync_clk_i(sync), .shared_comp_line_i(shared),
    .nv_store_o(nv_st), .nv_trim_o(nv_trim), .error_amp_reference_o(ref_o),
    .in_regulation_out_o(), .in_regulation_out_oe_o(pg_oe), .overvoltage_warning_o(overvoltage_warning),
    .shared_comp_line_o(), .shared_comp_line_oe_o(sh_oe), .switch_enable_o(sw_en),
    .switch_lock_o(), .margin_state_o(mst), .role_o(role));
  task automatic give_verdict;
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk) cmd <= '{1'b1, a, d};
    @(posedge clk) cmd.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge clk) cmd.addr <= a;
    @(posedge clk);
    #1 v = rdata;
  endtask
  task automatic do_reset(input logic s);
    @(posedge clk) rst_n <= 1'b0;
    strap <= s;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  function automatic int sat(logic [7:0] x, int mx);
    int s;
    s = $signed(x);
    return s < -64 ? -64 : (s > mx ? mx : s);
  endfunction
  int tbl[8][6] = '{'{'h33, 512, 1, 0, 0, 0}, '{'h33, 563, 1, 0, 1, 1}, '{'h33, 563, 0, 0, 1, 0},
    '{'h33, 430, 1, 0, 1, 0}, '{'h33, 522, 1, 0, 0, 0}, '{'h11, 522, 1, 0, 1, 1},
    '{'h99, 545, 1, 0, 1, 1}, '{'h33, 512, 1, 1, 1, 0}};
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end
  initial begin
    logic [15:0] v;
    logic [7:0] rt, rh, rl, op;
    int s;
    void'($urandom(39476));
    do_reset(1'b0);
    chk(16'(role == REFPG_ROLE_SLAVE), 16'h0);
    rd(`REFPG_OFS_VOUT_CMD, v);
    chk(v, `REFPG_RST_VOUT_CMD);
    rd(`REFPG_OFS_PCT_LIMITS, v);
    chk(v, {8'h00, `REFPG_RST_PCT_LIMITS});
    for (int i = 0; i < 12; i++) begin
      rt = 8'($urandom);
      rh = 8'($urandom);
      rl = 8'($urandom);
      op = 8'(i[1:0] << 4);
      s = 'h100 + $urandom_range(0, 'h2FF);
      wr(`REFPG_OFS_VREF_TRIM, {8'h00, rt});
      wr(`REFPG_OFS_MARGIN_HIGH, {8'h00, rh});
      wr(`REFPG_OFS_MARGIN_LOW, {8'h00, rl});
      wr(`REFPG_OFS_SCALE_LOOP, {15'h0, i[2]});
      wr(`REFPG_OFS_VOUT_CMD, 16'(s));
      wr(`REFPG_OFS_OPERATION, {8'h00, op});
      s = (i[2] ? s / 2 : s) + sat(rt, 63) + (op[5] ? sat(rh, 31) : 0) + (op[4] ? sat(rl, 31) : 0);
      s = s < `REFPG_DAC_MIN ? `REFPG_DAC_MIN : (s > `REFPG_DAC_MAX ? `REFPG_DAC_MAX : s);
      rd(8'h00, v);
      chk(v, 16'(s));
      chk(ref_o, 16'(s));
      chk(16'(mst), 16'(op[5] ? REFPG_MARGIN_HIGH : op[4] ? REFPG_MARGIN_LOW : REFPG_MARGIN_NONE));
      rd(`REFPG_OFS_MARGIN_LOW, v);
      chk(v, {8'h00, 8'(sat(rl, 31))});
    end
    wr(`REFPG_OFS_STORE_ALL, 16'h0);
    #1 chk(16'(nv_st), 16'h1);
    repeat (2) @(posedge clk);
    chk(16'(nv_st), 16'h0);
    chk({8'h00, nv_trim}, {8'h00, 8'(sat(rt, 63))});
    wr(`REFPG_OFS_VREF_TRIM, 16'h0);
    wr(`REFPG_OFS_SCALE_LOOP, 16'h0);
    wr(`REFPG_OFS_VOUT_CMD, 16'h0200);
    wr(`REFPG_OFS_OPERATION, 16'h0);
    foreach (tbl[r]) begin
      wr(`REFPG_OFS_PCT_LIMITS, 16'(tbl[r][0]));
      @(posedge clk) sense <= '{16'(tbl[r][1]), tbl[r][2] != 0, tbl[r][3] != 0};
      repeat (3) @(posedge clk);
      #1 chk(16'(pg_oe), 16'(tbl[r][4]));
      chk(16'(overvoltage_warning), 16'(tbl[r][5]));
      chk(16'(sh_oe), 16'(tbl[r][3]));
      chk(16'(sw_en), 16'(tbl[r][3] == 0));
      chk(16'(seq_ctl), 16'(tbl[r][4] == 0));
    end
    @(posedge clk) sense <= '{16'h0200, 1'b1, 1'b0};
    repeat (3) @(posedge clk);
    #1 chk(16'(sw_en), 16'h1);
    @(posedge clk) pflt <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk(16'(sw_en), 16'h0);
    chk(16'(sh_oe), 16'h0);
    chk(16'(pg_oe), 16'h1);
    @(posedge clk) pflt <= 1'b0;
    do_reset(1'b1);
    chk(16'(role), 16'(REFPG_ROLE_SLAVE));
    repeat (40) @(posedge clk);
    give_verdict();
  end
endmodule
